// *** hw/dual_lcd_cursor_split.sv ***
// Split panel LCD video block: register slave, paired fetches, concurrent halves and cursor placement
//
// Overview of operation
// [RULE_01] Software sets the LCD bit of the external control register before dual panel use.
// [RULE_02] Bit 13 of the main control register switches the video logic into duplex operation.
// [RULE_03] In duplex the upper and lower halves receive their data in the same output beat.
// [RULE_04] The first quad of each pair goes to the upper half, the second to the same place in the lower.
// [RULE_05] The block orders its own fetches, so the frame buffer is laid out as for one panel.
// [RULE_06] Bits 14:13 of the cursor begin register select off, upper, lower or straddling placement.
// [RULE_07] Normally begin and finish count rasters from vertical sync to the cursor's first and last line.
// [RULE_08] Software programs begin and finish as for one panel when the cursor sits in one half.
// [RULE_09] When straddling, begin marks the cursor end in the lower half and finish its start in the upper.
// [RULE_10] Straddling shows the lower half from display begin to begin, the upper from finish to display finish.
// [RULE_11] The top rasters of the lower half are sent alongside, not after, the bottom rasters of the upper; the code sends them with the upper top rasters.
// [RULE_12] In dual panel mode fetch requests always go out in pairs, one per half.
// [RULE_13] Placement 00 gives begin and finish their single panel meaning whatever the duplex state.
`timescale 1ns/1ps
`default_nettype none
`include "dual_lcd_defines.svh"
module dual_lcd_cursor_split (
   input wire logic clk,
   input wire logic rstn,
   // AXI4-Lite slave
   input wire logic [7:0] s_awaddr,
   input wire logic [2:0] s_awprot,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic [2:0] s_arprot,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Memory fetch side
   output logic fetch_req_valid,
   input wire logic fetch_req_ready,
   output logic fetch_req_lower,
   input wire logic quad_valid,
   input wire dual_lcd_pkg::quad_t quad_data,
   output logic quad_ready,
   // Panel side
   output dual_lcd_pkg::quad_t panel_upper,
   output dual_lcd_pkg::quad_t panel_lower,
   output logic panel_valid,
   output logic cursor_upper,
   output logic cursor_lower,
   output logic line_end,
   output logic frame_start,
   output logic lcd_mode,
   output logic duplex_mode
);
   logic [31:0] ext_r, main_r, cvb_r, cvf_r, dvb_r, dvf_r, line_r;
   logic aw_got_r, w_got_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_commit, ar_fire, aw_fire, w_fire;
   logic [31:0] rd_word;
   logic rd_hit, wr_hit;
   logic run, duplex;
   logic [1:0] place;
   dual_lcd_pkg::raster_t raster_r, cvb, cvf, dvb, dvf;
   logic [15:0] quad_cnt_r;
   logic last_quad, last_raster;
   dual_lcd_pkg::quad_pair_t pair;
   logic pair_valid;
   dual_lcd_pkg::cursor_on_t cur_nxt;

   // Address decode shared by the read and write paths
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a[1:0] == 2'h0) && (a <= `DL_OFF_STAT);
   endfunction

   // Byte lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            m[8*i +: 8] = dat[8*i +: 8];
      merge = m;
   endfunction

   // Inclusive raster window test
   function automatic logic in_span(input dual_lcd_pkg::raster_t r, input dual_lcd_pkg::raster_t lo,
                                    input dual_lcd_pkg::raster_t hi);
      in_span = (r >= lo) && (r <= hi);
   endfunction

   // Bus handshakes
   assign aw_fire = s_awvalid & s_awready;
   assign w_fire = s_wvalid & s_wready;
   assign ar_fire = s_arvalid & s_arready;
   assign wr_commit = aw_got_r & w_got_r & ~s_bvalid;
   assign wr_hit = reg_hit(aw_addr_r) && (aw_addr_r != `DL_OFF_STAT);
   assign rd_hit = reg_hit(s_araddr);

   // Address and data may arrive in either order; each is held until both are in
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_awready <= 1'b1;
         s_wready <= 1'b1;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else begin
         if (aw_fire) begin
            aw_addr_r <= s_awaddr;
            aw_got_r <= 1'b1;
            s_awready <= 1'b0;
         end else if (wr_commit) begin
            aw_got_r <= 1'b0;
         end
         if (w_fire) begin
            w_data_r <= s_wdata;
            w_strb_r <= s_wstrb;
            w_got_r <= 1'b1;
            s_wready <= 1'b0;
         end else if (wr_commit) begin
            w_got_r <= 1'b0;
         end
         if (s_bvalid && s_bready) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
         end
      end
   end

   // Write response one cycle after both halves of a write are held
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_bvalid <= 1'b0;
         s_bresp <= `DL_RESP_OKAY;
      end else if (wr_commit) begin
         s_bvalid <= 1'b1;
         s_bresp <= wr_hit ? `DL_RESP_OKAY : `DL_RESP_SLVERR;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // Software registers; the status word is read only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ext_r <= `DL_RST_WORD;
         main_r <= `DL_RST_WORD;
         cvb_r <= `DL_RST_WORD;
         cvf_r <= `DL_RST_WORD;
         dvb_r <= `DL_RST_WORD;
         dvf_r <= `DL_RST_WORD;
         line_r <= `DL_RST_LINE;
      end else if (wr_commit && wr_hit) begin
         case (aw_addr_r)
            `DL_OFF_EXT: ext_r <= merge(ext_r, w_data_r, w_strb_r);
            `DL_OFF_MAIN: main_r <= merge(main_r, w_data_r, w_strb_r);
            `DL_OFF_CVB: cvb_r <= merge(cvb_r, w_data_r, w_strb_r); // RULE_06
            `DL_OFF_CVF: cvf_r <= merge(cvf_r, w_data_r, w_strb_r);
            `DL_OFF_DVB: dvb_r <= merge(dvb_r, w_data_r, w_strb_r);
            `DL_OFF_DVF: dvf_r <= merge(dvf_r, w_data_r, w_strb_r);
            `DL_OFF_LINE: line_r <= merge(line_r, w_data_r, w_strb_r);
            default: ext_r <= ext_r;
         endcase
      end
   end

   // Read data selection
   assign rd_word = (s_araddr == `DL_OFF_EXT) ? ext_r :
                    (s_araddr == `DL_OFF_MAIN) ? main_r :
                    (s_araddr == `DL_OFF_CVB) ? cvb_r :
                    (s_araddr == `DL_OFF_CVF) ? cvf_r :
                    (s_araddr == `DL_OFF_DVB) ? dvb_r :
                    (s_araddr == `DL_OFF_DVF) ? dvf_r :
                    (s_araddr == `DL_OFF_LINE) ? line_r :
                    {12'h000, cursor_upper, cursor_lower, duplex, run, 5'h00, raster_r};

   // Read answer is registered, so data appear the cycle after the address is taken
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= `DL_RESP_OKAY;
      end else if (ar_fire) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b1;
         s_rdata <= rd_hit ? rd_word : 32'h0000_0000;
         s_rresp <= rd_hit ? `DL_RESP_OKAY : `DL_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
         s_arready <= 1'b1;
      end
   end

   // Mode decode; duplex only counts when the panel is also set up as an LCD
   assign run = main_r[`DL_RUN_BIT];
   assign duplex = main_r[`DL_DUP_BIT] & ext_r[`DL_LCD_BIT]; // RULE_02 RULE_01
   assign place = cvb_r[`DL_PLACE_HI:`DL_PLACE_LO]; // RULE_06
   assign cvb = cvb_r[`DL_RASTER_HI:0];
   assign cvf = cvf_r[`DL_RASTER_HI:0];
   assign dvb = dvb_r[`DL_RASTER_HI:0];
   assign dvf = dvf_r[`DL_RASTER_HI:0];

   // The sequencer walks one linear buffer; software needs no split layout
   quad_pair_sequencer seq (
      .clk(clk),
      .rstn(rstn),
      .run(run),
      .duplex(duplex),
      .req_valid(fetch_req_valid), // RULE_05
      .req_ready(fetch_req_ready),
      .req_lower(fetch_req_lower),
      .quad_valid(quad_valid),
      .quad_data(quad_data),
      .quad_ready(quad_ready),
      .pair(pair),
      .pair_valid(pair_valid)
   );

   // Raster position counts per pair; both halves share one count
   assign last_quad = (quad_cnt_r >= line_r[15:0] - 16'h0001);
   assign last_raster = (raster_r >= dvf);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         quad_cnt_r <= 16'h0000;
         raster_r <= '0;
      end else if (pair_valid) begin
         if (last_quad) begin
            quad_cnt_r <= 16'h0000;
            raster_r <= last_raster ? dual_lcd_pkg::raster_t'(0) : raster_r + 11'h001; // RULE_11
         end else begin
            quad_cnt_r <= quad_cnt_r + 16'h0001;
         end
      end
   end

   // Cursor windows by placement; straddling swaps the meaning of begin and finish
   always_comb begin
      cur_nxt = '0;
      case (place)
         `DL_PLACE_OFF: cur_nxt.upper = in_span(raster_r, cvb, cvf); // RULE_13 RULE_07
         `DL_PLACE_UPPER: cur_nxt.upper = in_span(raster_r, cvb, cvf); // RULE_07
         `DL_PLACE_LOWER: cur_nxt.lower = in_span(raster_r, cvb, cvf); // RULE_07
         `DL_PLACE_STRADDLE: begin
            cur_nxt.lower = in_span(raster_r, dvb, cvb); // RULE_09 RULE_10
            cur_nxt.upper = in_span(raster_r, cvf, dvf); // RULE_09 RULE_10
         end
         default: cur_nxt = '0;
      endcase
      if (!duplex && place != `DL_PLACE_OFF)
         cur_nxt = '{upper: in_span(raster_r, cvb, cvf), lower: 1'b0};
   end

   // Both halves leave on the same beat, lower top rasters beside upper top ones
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         panel_upper <= '0;
         panel_lower <= '0;
         panel_valid <= 1'b0;
         cursor_upper <= 1'b0;
         cursor_lower <= 1'b0;
         line_end <= 1'b0;
         frame_start <= 1'b0;
      end else begin
         panel_valid <= pair_valid; // RULE_03
         line_end <= pair_valid & last_quad;
         frame_start <= pair_valid & last_quad & last_raster;
         if (pair_valid) begin
            panel_upper <= pair.upper; // RULE_03
            panel_lower <= pair.lower; // RULE_03
            cursor_upper <= cur_nxt.upper;
            cursor_lower <= cur_nxt.lower;
         end
      end
   end

   // Mode levels for the panel drivers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lcd_mode <= 1'b0;
         duplex_mode <= 1'b0;
      end else begin
         lcd_mode <= ext_r[`DL_LCD_BIT];
         duplex_mode <= duplex;
      end
   end
endmodule // dual_lcd_cursor_split
`default_nettype wire

// *** hw/quad_pair_sequencer.sv ***
// Fetch sequencer that asks for quad words and steers them to the two panel halves
`timescale 1ns/1ps
`default_nettype none
module quad_pair_sequencer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic duplex,
   output logic req_valid,
   input wire logic req_ready,
   output logic req_lower,
   input wire logic quad_valid,
   input wire dual_lcd_pkg::quad_t quad_data,
   output logic quad_ready,
   output dual_lcd_pkg::quad_pair_t pair,
   output logic pair_valid
);
   dual_lcd_pkg::fetch_state_t state_r, state_nxt;
   logic dup_pair_r;
   logic req_fire, quad_fire, start_pair;

   assign req_fire = req_valid & req_ready;
   assign quad_fire = quad_valid & quad_ready;
   assign start_pair = (state_r == dual_lcd_pkg::ASK_UP) & run & ~req_valid;

   // Requests go out upper then lower, data come back in that order
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dual_lcd_pkg::ASK_UP: begin
            if (req_fire)
               state_nxt = dup_pair_r ? dual_lcd_pkg::ASK_LO : dual_lcd_pkg::TAKE_UP; // RULE_12
         end
         dual_lcd_pkg::ASK_LO: begin
            if (req_fire)
               state_nxt = dual_lcd_pkg::TAKE_UP;
         end
         dual_lcd_pkg::TAKE_UP: begin
            if (quad_fire)
               state_nxt = dup_pair_r ? dual_lcd_pkg::TAKE_LO : dual_lcd_pkg::ASK_UP; // RULE_04
         end
         dual_lcd_pkg::TAKE_LO: begin
            if (quad_fire)
               state_nxt = dual_lcd_pkg::ASK_UP;
         end
         default: state_nxt = dual_lcd_pkg::ASK_UP;
      endcase
   end

   // Duplex is frozen per pair so a mode change never splits a pair
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= dual_lcd_pkg::ASK_UP;
         dup_pair_r <= 1'b0;
         req_valid <= 1'b0;
         req_lower <= 1'b0;
         quad_ready <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (start_pair)
            dup_pair_r <= duplex; // RULE_12
         req_valid <= (start_pair | (state_nxt == dual_lcd_pkg::ASK_LO)) & ~(req_fire & state_nxt != state_r)
                      | (req_valid & ~req_fire);
         req_lower <= (state_nxt == dual_lcd_pkg::ASK_LO);
         quad_ready <= (state_nxt == dual_lcd_pkg::TAKE_UP) | (state_nxt == dual_lcd_pkg::TAKE_LO);
      end
   end

   // First quad of a pair feeds the upper half, second the lower half
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pair <= '0;
         pair_valid <= 1'b0;
      end else begin
         if (quad_fire && state_r == dual_lcd_pkg::TAKE_UP) begin
            pair.upper <= quad_data; // RULE_04
            if (!dup_pair_r)
               pair.lower <= '0;
         end
         if (quad_fire && state_r == dual_lcd_pkg::TAKE_LO)
            pair.lower <= quad_data; // RULE_04
         pair_valid <= quad_fire & ((state_r == dual_lcd_pkg::TAKE_LO) | ~dup_pair_r);
      end
   end
endmodule // quad_pair_sequencer
`default_nettype wire

// *** include/dual_lcd_defines.svh ***
// Register offsets, field positions, placement codes, reset values and response codes of the split panel video block
`ifndef DUAL_LCD_DEFINES_SVH
`define DUAL_LCD_DEFINES_SVH

`define DL_OFF_EXT 8'h00
`define DL_OFF_MAIN 8'h04
`define DL_OFF_CVB 8'h08
`define DL_OFF_CVF 8'h0c
`define DL_OFF_DVB 8'h10
`define DL_OFF_DVF 8'h14
`define DL_OFF_LINE 8'h18
`define DL_OFF_STAT 8'h1c

`define DL_LCD_BIT 13
`define DL_DUP_BIT 13
`define DL_RUN_BIT 0
`define DL_PLACE_HI 14
`define DL_PLACE_LO 13
`define DL_RASTER_HI 10

`define DL_PLACE_OFF 2'h0
`define DL_PLACE_UPPER 2'h1
`define DL_PLACE_LOWER 2'h2
`define DL_PLACE_STRADDLE 2'h3

`define DL_RST_WORD 32'h0000_0000
`define DL_RST_LINE 32'h0000_0028
`define DL_RESP_OKAY 2'h0
`define DL_RESP_SLVERR 2'h2

`endif

// *** include/dual_lcd_pkg.sv ***
// Types shared by the split panel video block
package dual_lcd_pkg;
   typedef logic [10:0] raster_t;
   typedef logic [127:0] quad_t;
   typedef struct packed {
      quad_t upper;
      quad_t lower;
   } quad_pair_t;
   typedef struct packed {
      logic upper;
      logic lower;
   } cursor_on_t;
   typedef enum logic [1:0] {ASK_UP, ASK_LO, TAKE_UP, TAKE_LO} fetch_state_t;
endpackage

// *** tb/dual_lcd_cursor_split_props.sv ***
// Checker for the split panel video block
`timescale 1ns/1ps
`default_nettype none
module dual_lcd_cursor_split_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic s_bvalid,
   input wire logic s_bready,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic s_rvalid,
   input wire logic fetch_req_valid,
   input wire logic fetch_req_ready,
   input wire logic fetch_req_lower,
   input wire logic quad_valid,
   input wire dual_lcd_pkg::quad_t quad_data,
   input wire logic quad_ready,
   input wire dual_lcd_pkg::quad_t panel_upper,
   input wire dual_lcd_pkg::quad_t panel_lower,
   input wire logic panel_valid,
   input wire logic line_end,
   input wire logic frame_start,
   input wire logic lcd_mode,
   input wire logic duplex_mode
);
   logic [1:0] n_q_r;
   logic last_low_r;
   dual_lcd_pkg::quad_t q_last_r;
   dual_lcd_pkg::quad_t q_prev_r;
   wire q_take = quad_valid && quad_ready;
   wire r_take = fetch_req_valid && fetch_req_ready;
   // Quads since the last beat tell whether a beat closed a pair
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         n_q_r <= 2'h0;
         last_low_r <= 1'b1;
         q_last_r <= '0;
         q_prev_r <= '0;
      end else begin
         n_q_r <= panel_valid ? {1'b0, q_take} : n_q_r + {1'b0, q_take};
         last_low_r <= r_take ? fetch_req_lower : last_low_r;
         q_last_r <= q_take ? quad_data : q_last_r;
         q_prev_r <= q_take ? q_last_r : q_prev_r;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_beat1;
      panel_valid && n_q_r == 2'h1;
   endsequence
   sequence s_beat2;
      panel_valid && n_q_r == 2'h2;
   endsequence
   sequence s_req_wait;
      fetch_req_valid && !fetch_req_ready;
   endsequence
   sequence s_low_req;
      r_take && fetch_req_lower;
   endsequence
   // The closing quad is taken two edges before its beat is sampled
   a_beat_has_quad: assert property (panel_valid |-> $past(q_take, 2) && n_q_r != 2'h0)
      else $error("beat without a fresh quad");
   a_pair_halves: assert property (s_beat2 |-> panel_upper == q_prev_r && panel_lower == q_last_r)
      else $error("pair halves swapped or stale");
   a_single_beat: assert property (s_beat1 |-> panel_upper == q_last_r && panel_lower == '0)
      else $error("single beat data wrong");
   a_lower_follows: assert property (s_low_req |-> !last_low_r)
      else $error("lower request not paired with upper");
   a_pair_closes: assert property (s_low_req |-> ##[1:300] panel_valid)
      else $error("pair never reached the panel");
   a_req_stands: assert property (s_req_wait |=> fetch_req_valid && $stable(fetch_req_lower))
      else $error("fetch request dropped");
   a_dup_needs_lcd: assert property (duplex_mode |-> lcd_mode)
      else $error("duplex without lcd mode");
   a_frame_on_beat: assert property (frame_start |-> panel_valid && line_end)
      else $error("frame start off a raster end");
   // Both halves are held for one edge before the commit raises the response
   a_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
      else $error("write response late");
   a_b_stands: assert property (s_bvalid && !s_bready |=> s_bvalid)
      else $error("write response dropped");
   a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready)
      else $error("read response late");
endmodule // dual_lcd_cursor_split_props
bind dual_lcd_cursor_split dual_lcd_cursor_split_props props_i (.*);
`default_nettype wire

// *** tb/dual_lcd_cursor_split_tb.sv ***
// Self-checking bench for the split panel video block
`timescale 1ns/1ps
`default_nettype none
module dual_lcd_cursor_split_tb;
   logic clk, rstn, stall, stall_en;
   logic [7:0] s_awaddr, s_araddr;
   logic [2:0] s_awprot, s_arprot;
   logic [3:0] s_wstrb;
   logic [31:0] s_wdata, s_rdata;
   logic [1:0] s_bresp, s_rresp;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready;
   logic fetch_req_valid, fetch_req_ready, fetch_req_lower, quad_valid, quad_ready;
   dual_lcd_pkg::quad_t quad_data, panel_upper, panel_lower;
   logic panel_valid, cursor_upper, cursor_lower, line_end, frame_start, lcd_mode, duplex_mode;
   integer seed, err_total, check_count, beats, rast, ser_e, i;
   logic dup_e;
   logic [1:0] pl_e;
   logic [10:0] cb_e, cf_e, t;
   logic [1:0] tpl [5] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h3};
   logic [4:0] tdup = 5'b11100;

   dual_lcd_cursor_split dut (.*);
   quad_mem_model mem (.clk(clk), .rstn(rstn), .stall(stall), .req_valid(fetch_req_valid),
      .req_ready(fetch_req_ready), .req_lower(fetch_req_lower), .quad_valid(quad_valid),
      .quad_data(quad_data), .quad_ready(quad_ready));

   // Clock of 100 ns
   always #50 clk = ~clk;

   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (s_awvalid && s_awready) begin
            aw = 1'b1;
            s_awvalid <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w = 1'b1;
            s_wvalid <= 1'b0;
         end
      end
      // A late ready leaves the response waiting on the bus now and then
      repeat ($unsigned($random(seed)) % 3) @(posedge clk);
      s_bready <= 1'b1;
      do @(posedge clk); while (s_bvalid !== 1'b1);
      check("bresp", s_bresp, er);
      s_bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do @(posedge clk); while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      do @(posedge clk); while (s_rvalid !== 1'b1);
      check("rdata", {s_rresp, s_rdata}, {er, ed});
      s_rready <= 1'b0;
      // One idle edge so mode outputs have settled before the caller looks
      @(posedge clk);
   endtask

   // Expected cursor halves for a raster; display window is rasters 1 to 5
   function automatic logic [1:0] cur(input integer r);
      logic w;
      w = r >= cb_e && r <= cf_e;
      if (!dup_e || pl_e == 2'h0) return {w, 1'b0};
      if (pl_e == 2'h1) return {w, 1'b0};
      if (pl_e == 2'h2) return {1'b0, w};
      return {r >= cf_e && r <= 5, r >= 1 && r <= cb_e};
   endfunction

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Random stalls on the memory side while a run is active
   always @(posedge clk) stall <= stall_en && (($random(seed) & 3) == 0);

   // Every beat: data halves, cursor halves and raster framing
   always @(posedge clk) if (rstn && panel_valid === 1'b1) begin
      check("upper", panel_upper, {1'b0, 95'h0, ser_e[31:0]});
      check("lower", panel_lower, dup_e ? {1'b1, 95'h0, ser_e[31:0] + 32'h1} : 128'h0);
      check("cursor", {cursor_upper, cursor_lower}, cur(rast));
      check("framing", {line_end, frame_start}, {1'b1, rast == 5});
      ser_e = ser_e + (dup_e ? 2 : 1);
      rast = (rast == 5) ? 0 : rast + 1;
      beats++;
   end

   // Hang guard, well past the expected run length
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      $display("ERROR watchdog expected finish seen hang");
      end_of_test;
   end

   initial begin
      {clk, rstn, stall, stall_en, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {s_awaddr, s_araddr, s_awprot, s_arprot, s_wdata} = '0;
      s_wstrb = 4'hf;
      {seed, err_total, check_count, beats, rast, ser_e} = {32'd98731, 160'h0};
      {dup_e, pl_e, cb_e, cf_e} = '0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd(8'h18, 32'h28, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      wr(8'h1c, 32'h1, 2'h2);
      rd(8'h22, 32'h0, 2'h2);
      wr(8'h04, 32'h2000, 2'h0);
      check("modes", {lcd_mode, duplex_mode}, 2'b00);
      wr(8'h00, 32'h2000, 2'h0);
      check("modes", {lcd_mode, duplex_mode}, 2'b11);
      wr(8'h18, 32'h1, 2'h0);
      wr(8'h10, 32'h1, 2'h0);
      wr(8'h14, 32'h5, 2'h0);
      $display("register tests done");
      for (i = 0; i < 5; i++) begin
         dup_e = tdup[i];
         pl_e = tpl[i];
         cb_e = 11'($unsigned($random(seed)) % 6);
         cf_e = 11'($unsigned($random(seed)) % 6);
         if (pl_e != 2'h3 && cb_e > cf_e) begin
            t = cb_e;
            cb_e = cf_e;
            cf_e = t;
         end
         wr(8'h08, {17'h0, pl_e, 2'h0, cb_e}, 2'h0);
         wr(8'h0c, {21'h0, cf_e}, 2'h0);
         stall_en <= 1'b1;
         beats = 0;
         wr(8'h04, {18'h0, dup_e, 12'h0, 1'b1}, 2'h0);
         while (beats < 14) @(posedge clk);
         wr(8'h04, {18'h0, dup_e, 13'h0}, 2'h0);
         stall_en <= 1'b0;
         repeat (30) @(posedge clk);
         $display("run %0d done, %0d beats", i, beats);
      end
      end_of_test;
   end
endmodule // dual_lcd_cursor_split_tb
`default_nettype wire

// *** tb/quad_mem_model.sv ***
// Memory model that answers quad fetch requests in order
`timescale 1ns/1ps
`default_nettype none
module quad_mem_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic stall,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_lower,
   output logic quad_valid,
   output dual_lcd_pkg::quad_t quad_data,
   input wire logic quad_ready
);
   logic [32:0] pend[$];
   logic [31:0] ser;
   // Stalls refuse requests, so the block must hold them
   assign req_ready = !stall;
   // Quad carries the half flag and a serial; idle data keeps changing
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pend.delete();
         ser = 32'h0;
         quad_valid <= 1'b0;
         quad_data <= '0;
      end else begin
         if (req_valid && req_ready) begin
            pend.push_back({req_lower, ser});
            ser = ser + 32'h1;
         end
         if (quad_valid && !quad_ready) begin
         end else if (pend.size() > 0 && !stall) begin
            quad_valid <= 1'b1;
            quad_data <= {pend[0][32], 95'h0, pend[0][31:0]};
            void'(pend.pop_front());
         end else begin
            quad_valid <= 1'b0;
            quad_data <= ~quad_data;
         end
      end
   end
endmodule // quad_mem_model
`default_nettype wire
